// file: verilog/tps_pkg.sv
/*
  Constants for the TFT panel sync timing generator: register offsets,
  control field positions, reset values and timing defaults.
  Assumes a 4-bit register address and 16-bit register data.
*/
package tps_pkg;
  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [3:0] TPS_OFF_CTRL = 4'h0;
  localparam logic [3:0] TPS_OFF_CLKDIV = 4'h1;
  localparam logic [3:0] TPS_OFF_HSW = 4'h2;
  localparam logic [3:0] TPS_OFF_HSTART = 4'h3;
  localparam logic [3:0] TPS_OFF_HACT = 4'h4;
  localparam logic [3:0] TPS_OFF_HTOTAL = 4'h5;
  localparam logic [3:0] TPS_OFF_VSW = 4'h6;
  localparam logic [3:0] TPS_OFF_VSTART = 4'h7;
  localparam logic [3:0] TPS_OFF_VACT = 4'h8;
  localparam logic [3:0] TPS_OFF_VTOTAL = 4'h9;
  localparam logic [3:0] TPS_OFF_STATUS = 4'hA;
  localparam logic [3:0] TPS_OFF_LINE = 4'hB;
  // ************************************************************
  // Control and status fields
  // ************************************************************
  localparam int TPS_CTRL_EN = 0;
  localparam int TPS_CTRL_CLK_INV = 1;
  localparam int TPS_CTRL_LS_LOW = 2;
  localparam int TPS_CTRL_FS_LOW = 3;
  localparam int TPS_CTRL_DR_LOW = 4;
  localparam int TPS_ST_UNDERRUN = 0;
  localparam int TPS_ST_FRAME = 1;
  localparam int TPS_ST_ACTIVE = 2;
  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [15:0] TPS_RST_CTRL = 16'h0000;
  localparam logic [15:0] TPS_RST_CLKDIV = 16'h0001;
  localparam logic [15:0] TPS_RST_HSW = 16'h000A;
  localparam logic [15:0] TPS_RST_HSTART = 16'h0014;
  localparam logic [15:0] TPS_RST_HACT = 16'h0140;
  localparam logic [15:0] TPS_RST_HTOTAL = 16'h0190;
  localparam logic [15:0] TPS_RST_VSW = 16'h0002;
  localparam logic [15:0] TPS_RST_VSTART = 16'h0004;
  localparam logic [15:0] TPS_RST_VACT = 16'h00F0;
  localparam logic [15:0] TPS_RST_VTOTAL = 16'h00FA;
endpackage

// file: verilog/tps_timing.sv
/*
  TFT panel sync timing generator with its pixel FIFO.
  Holds tps_fifo and the top module tps_timing. Assumes a single
  125 MHz clock, a synchronous active-high reset, a register master
  on the same clock and a pixel source on the same clock.
*/
// Operation
// RULE1: with normal clock polarity the panel captures data on the falling edge
// RULE2: pixel clock runs without a gap while the interface is enabled
// RULE3: one line sync pulse is sent for every display line
// RULE4: one frame sync assertion is sent for every frame
// RULE5: frame sync spans at least one whole line sync pulse
// RULE6: data ready is high only while valid pixel words are driven
// RULE7: panel ignores the pixel bus while data ready is inactive
// RULE8: all horizontal intervals come from programmable registers
// RULE9: all vertical intervals come from programmable registers
// RULE10: clock polarity and sync, frame, ready levels are selectable
// RULE11: outputs change on the edge opposite the panel capture edge
`timescale 1ns/1ps

// ************************************************************
// Pixel FIFO
// ************************************************************
module tps_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic rdy_r, rdy_nxt, empty_r, empty_nxt;
  logic push, pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("tps_fifo: DEPTH must be a power of two, at least 2");
  end

  assign in_ready = rdy_r;
  assign out_valid = ~empty_r;
  assign out_data = mem[rp_r];
  assign push = in_valid & rdy_r;
  assign pop = out_ready & ~empty_r;

  // Pointer and flag update; flags are registered so ready is a flop
  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
    rdy_nxt = (cnt_nxt != (AW + 1)'(DEPTH));
    empty_nxt = (cnt_nxt == '0);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b1;
      empty_r <= 1'b1;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
      empty_r <= empty_nxt;
    end
  end

  // Storage has no reset; empty flag guards stale words
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule

// ************************************************************
// Timing generator top
// ************************************************************
module tps_timing import tps_pkg::*; #(
  parameter int PIX_W = 24,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [3:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  input wire logic [PIX_W-1:0] PIX_DATA,
  input wire logic PIX_VALID,
  output logic PIX_READY,
  output logic PANEL_PIXEL_CLOCK,
  output logic PANEL_LINE_SYNC,
  output logic PANEL_FRAME_SYNC,
  output logic PANEL_DATA_READY,
  output logic [PIX_W-1:0] PANEL_DATA
);
  if (PIX_W < 1 || FIFO_DEPTH < 2) begin : g_chk
    $error("tps_timing: bad PIX_W or FIFO_DEPTH");
  end

  // ************************************************************
  // Register file
  // ************************************************************
  logic [15:0] ctrl_r, ctrl_nxt, div_r, div_nxt;
  logic [15:0] hsw_r, hsw_nxt, hst_r, hst_nxt;
  logic [15:0] hact_r, hact_nxt, htot_r, htot_nxt;
  logic [15:0] vsw_r, vsw_nxt, vst_r, vst_nxt;
  logic [15:0] vact_r, vact_nxt, vtot_r, vtot_nxt;
  logic udr_r, udr_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [15:0] h_r, h_nxt, v_r, v_nxt;
  logic underrun;
  logic fs_now, act_now;

  // Writes steer the timing; underrun is write-one-to-clear, set wins
  always_comb begin
    ctrl_nxt = ctrl_r;
    div_nxt = div_r;
    hsw_nxt = hsw_r;
    hst_nxt = hst_r;
    hact_nxt = hact_r;
    htot_nxt = htot_r;
    vsw_nxt = vsw_r;
    vst_nxt = vst_r;
    vact_nxt = vact_r;
    vtot_nxt = vtot_r;
    udr_nxt = udr_r;
    if (REG_WR) begin
      case (REG_ADDR)
        TPS_OFF_CTRL: ctrl_nxt = REG_WDATA;
        TPS_OFF_CLKDIV: div_nxt = REG_WDATA;
        TPS_OFF_HSW: hsw_nxt = REG_WDATA; // RULE8
        TPS_OFF_HSTART: hst_nxt = REG_WDATA; // RULE8
        TPS_OFF_HACT: hact_nxt = REG_WDATA; // RULE8
        TPS_OFF_HTOTAL: htot_nxt = REG_WDATA; // RULE8
        TPS_OFF_VSW: vsw_nxt = REG_WDATA; // RULE9
        TPS_OFF_VSTART: vst_nxt = REG_WDATA; // RULE9
        TPS_OFF_VACT: vact_nxt = REG_WDATA; // RULE9
        TPS_OFF_VTOTAL: vtot_nxt = REG_WDATA; // RULE9
        TPS_OFF_STATUS: begin
          if (REG_WDATA[TPS_ST_UNDERRUN]) begin
            udr_nxt = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (underrun) begin
      udr_nxt = 1'b1;
    end
    rdata_nxt = 16'h0000;
    if (REG_RD) begin
      case (REG_ADDR)
        TPS_OFF_CTRL: rdata_nxt = ctrl_r;
        TPS_OFF_CLKDIV: rdata_nxt = div_r;
        TPS_OFF_HSW: rdata_nxt = hsw_r;
        TPS_OFF_HSTART: rdata_nxt = hst_r;
        TPS_OFF_HACT: rdata_nxt = hact_r;
        TPS_OFF_HTOTAL: rdata_nxt = htot_r;
        TPS_OFF_VSW: rdata_nxt = vsw_r;
        TPS_OFF_VSTART: rdata_nxt = vst_r;
        TPS_OFF_VACT: rdata_nxt = vact_r;
        TPS_OFF_VTOTAL: rdata_nxt = vtot_r;
        TPS_OFF_STATUS: rdata_nxt = {13'h0000, act_now, fs_now, udr_r};
        TPS_OFF_LINE: rdata_nxt = v_r;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl_r <= TPS_RST_CTRL;
      div_r <= TPS_RST_CLKDIV;
      hsw_r <= TPS_RST_HSW;
      hst_r <= TPS_RST_HSTART;
      hact_r <= TPS_RST_HACT;
      htot_r <= TPS_RST_HTOTAL;
      vsw_r <= TPS_RST_VSW;
      vst_r <= TPS_RST_VSTART;
      vact_r <= TPS_RST_VACT;
      vtot_r <= TPS_RST_VTOTAL;
      udr_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      div_r <= div_nxt;
      hsw_r <= hsw_nxt;
      hst_r <= hst_nxt;
      hact_r <= hact_nxt;
      htot_r <= htot_nxt;
      vsw_r <= vsw_nxt;
      vst_r <= vst_nxt;
      vact_r <= vact_nxt;
      vtot_r <= vtot_nxt;
      udr_r <= udr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign REG_RDATA = rdata_r;

  // ************************************************************
  // Pixel clock divider and raster counters
  // ************************************************************
  logic en;
  logic [15:0] dc_r, dc_nxt;
  logic pclk_r, pclk_nxt, tick;
  logic line_end, frame_end;
  logic [15:0] vsw_eff;

  assign en = ctrl_r[TPS_CTRL_EN];
  // A zero width would leave no sync at all, so one line is the floor
  assign vsw_eff = (vsw_r == 16'h0000) ? 16'h0001 : vsw_r; // RULE5
  assign line_end = (h_r + 16'h0001 >= htot_r);
  assign frame_end = (v_r + 16'h0001 >= vtot_r);

  // Free running half-period divider; tick marks the internal rise
  always_comb begin
    dc_nxt = dc_r;
    pclk_nxt = pclk_r;
    tick = 1'b0;
    h_nxt = h_r;
    v_nxt = v_r;
    if (!en) begin
      dc_nxt = 16'h0000;
      pclk_nxt = 1'b0;
      h_nxt = 16'h0000;
      v_nxt = 16'h0000;
    end else if (dc_r >= div_r) begin
      dc_nxt = 16'h0000;
      pclk_nxt = ~pclk_r; // RULE2
      tick = ~pclk_r;
    end else begin
      dc_nxt = dc_r + 16'h0001;
    end
    if (tick) begin
      if (line_end) begin
        h_nxt = 16'h0000; // RULE3
        v_nxt = frame_end ? 16'h0000 : v_r + 16'h0001; // RULE4
      end else begin
        h_nxt = h_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      dc_r <= 16'h0000;
      pclk_r <= 1'b0;
      h_r <= 16'h0000;
      v_r <= 16'h0000;
    end else begin
      dc_r <= dc_nxt;
      pclk_r <= pclk_nxt;
      h_r <= h_nxt;
      v_r <= v_nxt;
    end
  end

  // ************************************************************
  // Panel outputs
  // ************************************************************
  logic ls_now, dr_now;
  logic f_valid, f_pop;
  logic [PIX_W-1:0] f_data;
  logic pc_pin_r, pc_pin_nxt, ls_pin_r, ls_pin_nxt;
  logic fs_pin_r, fs_pin_nxt, dr_pin_r, dr_pin_nxt;
  logic [PIX_W-1:0] pd_r, pd_nxt;

  assign ls_now = (h_r < hsw_r); // RULE3
  // Whole lines from line start, so each hsync pulse is covered
  assign fs_now = en & (v_r < vsw_eff); // RULE5
  assign act_now = en && (h_r >= hst_r) && (h_r - hst_r < hact_r)
    && (v_r >= vst_r) && (v_r - vst_r < vact_r);
  // Only a word really taken from the FIFO may qualify the bus
  assign dr_now = act_now & f_valid; // RULE6
  assign f_pop = tick & dr_now;
  assign underrun = tick & act_now & ~f_valid;

  tps_fifo #(
    .WIDTH(PIX_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(REF_CLK),
    .rst(RST),
    .in_data(PIX_DATA),
    .in_valid(PIX_VALID),
    .in_ready(PIX_READY),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_pop)
  );

  // While enabled, data and sync pins change only at the internal rise, half a period before the
  // panel samples at the internal fall; the clock pin gets the inversion
  always_comb begin
    pc_pin_nxt = pclk_nxt ^ ctrl_r[TPS_CTRL_CLK_INV]; // RULE1 RULE10
    ls_pin_nxt = ls_pin_r;
    fs_pin_nxt = fs_pin_r;
    dr_pin_nxt = dr_pin_r;
    pd_nxt = pd_r;
    if (!en) begin
      ls_pin_nxt = ctrl_r[TPS_CTRL_LS_LOW];
      fs_pin_nxt = ctrl_r[TPS_CTRL_FS_LOW];
      dr_pin_nxt = ctrl_r[TPS_CTRL_DR_LOW];
      pd_nxt = '0;
    end else if (tick) begin
      ls_pin_nxt = ls_now ^ ctrl_r[TPS_CTRL_LS_LOW]; // RULE11 RULE10
      fs_pin_nxt = fs_now ^ ctrl_r[TPS_CTRL_FS_LOW]; // RULE11 RULE10
      dr_pin_nxt = dr_now ^ ctrl_r[TPS_CTRL_DR_LOW]; // RULE11 RULE10
      pd_nxt = dr_now ? f_data : '0; // RULE11
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pc_pin_r <= 1'b0;
      ls_pin_r <= 1'b0;
      fs_pin_r <= 1'b0;
      dr_pin_r <= 1'b0;
      pd_r <= '0;
    end else begin
      pc_pin_r <= pc_pin_nxt;
      ls_pin_r <= ls_pin_nxt;
      fs_pin_r <= fs_pin_nxt;
      dr_pin_r <= dr_pin_nxt;
      pd_r <= pd_nxt;
    end
  end

  assign PANEL_PIXEL_CLOCK = pc_pin_r;
  assign PANEL_LINE_SYNC = ls_pin_r;
  assign PANEL_FRAME_SYNC = fs_pin_r;
  assign PANEL_DATA_READY = dr_pin_r;
  assign PANEL_DATA = pd_r;
endmodule

// file: testbench/tps_timing_props.sv
/*
  Checker for the panel pins and register read data of tps_timing, bound to its ports.
  Assumes settings only change while the panel is disabled.
*/
`timescale 1ns/1ps
// ****************************************
// Pin checker
// ****************************************
module tps_timing_props import tps_pkg::*; #(
  parameter int PIX_W = 24,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [3:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic [PIX_W-1:0] PIX_DATA,
  input wire logic PIX_VALID,
  input wire logic PIX_READY,
  input wire logic PANEL_PIXEL_CLOCK,
  input wire logic PANEL_LINE_SYNC,
  input wire logic PANEL_FRAME_SYNC,
  input wire logic PANEL_DATA_READY,
  input wire logic [PIX_W-1:0] PANEL_DATA
);
  logic [4:0] ctrl_r;
  logic [4:0] ctrl_q;
  logic [15:0] hsw_r;
  logic [15:0] div_r;
  logic [31:0] ls_cnt;
  logic [31:0] ck_cnt;
  logic en;
  logic st;
  logic ls_a;
  logic fs_a;
  logic dr_a;
  // Active levels; st masks the cycle in which the control setting moves
  assign en = ctrl_r[TPS_CTRL_EN];
  assign st = ctrl_r == ctrl_q;
  assign ls_a = en && (PANEL_LINE_SYNC != ctrl_r[TPS_CTRL_LS_LOW]);
  assign fs_a = en && (PANEL_FRAME_SYNC != ctrl_r[TPS_CTRL_FS_LOW]);
  assign dr_a = PANEL_DATA_READY != ctrl_r[TPS_CTRL_DR_LOW];
  // Shadow of the settings, plus pulse and half-period counters
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl_r <= TPS_RST_CTRL[4:0];
      ctrl_q <= TPS_RST_CTRL[4:0];
      hsw_r <= TPS_RST_HSW;
      div_r <= TPS_RST_CLKDIV;
      ls_cnt <= 32'h0;
      ck_cnt <= 32'h0;
    end else begin
      ctrl_q <= ctrl_r;
      ls_cnt <= ls_a ? ls_cnt + 32'h1 : 32'h0;
      ck_cnt <= $changed(PANEL_PIXEL_CLOCK) ? 32'h1 : ck_cnt + 32'h1;
      if (REG_WR && REG_ADDR == TPS_OFF_CTRL) ctrl_r <= REG_WDATA[4:0];
      if (REG_WR && REG_ADDR == TPS_OFF_HSW) hsw_r <= REG_WDATA;
      if (REG_WR && REG_ADDR == TPS_OFF_CLKDIV) div_r <= REG_WDATA;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Skips the first ticks after enable, where the idle time is counted
  property p_clk_run;
    en && $past(en, 8) |-> ck_cnt <= 32'(div_r) + 32'h1;
  endproperty
  a_clk_run: assert property (p_clk_run) else $error("clock gap");
  property p_edge;
    en && $past(en) && st && ($changed(PANEL_LINE_SYNC) ||
      $changed(PANEL_FRAME_SYNC) || $changed(PANEL_DATA_READY) ||
      $changed(PANEL_DATA)) |-> $changed(PANEL_PIXEL_CLOCK) &&
      PANEL_PIXEL_CLOCK != ctrl_r[TPS_CTRL_CLK_INV];
  endproperty
  a_edge: assert property (p_edge) else $error("pin off edge");
  property p_dr_data;
    !dr_a && st |-> PANEL_DATA == '0;
  endproperty
  a_dr_data: assert property (p_dr_data) else $error("data unqualified");
  property p_idle;
    !en && !$past(en) && st |-> PANEL_PIXEL_CLOCK == ctrl_r[1] &&
      PANEL_LINE_SYNC == ctrl_r[2] && PANEL_FRAME_SYNC == ctrl_r[3] &&
      PANEL_DATA_READY == ctrl_r[4];
  endproperty
  a_idle: assert property (p_idle) else $error("idle level");
  property p_fs_start;
    $rose(fs_a) |-> $rose(ls_a);
  endproperty
  a_fs_start: assert property (p_fs_start) else $error("frame start");
  property p_fs_end;
    $fell(fs_a) && en |-> !$past(ls_a);
  endproperty
  a_fs_end: assert property (p_fs_end) else $error("frame end");
  property p_ls_width;
    $fell(ls_a) && en |->
      ls_cnt == 32'(hsw_r) * 32'(div_r + 16'h1) * 32'h2;
  endproperty
  a_ls_width: assert property (p_ls_width) else $error("line width");
  property p_rd_idle;
    !$past(REG_RD) |-> REG_RDATA == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data held");
endmodule
bind tps_timing tps_timing_props #(.PIX_W(PIX_W), .FIFO_DEPTH(FIFO_DEPTH))
  u_props (.REF_CLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
  .REG_RDATA, .PIX_DATA, .PIX_VALID, .PIX_READY, .PANEL_PIXEL_CLOCK,
  .PANEL_LINE_SYNC, .PANEL_FRAME_SYNC, .PANEL_DATA_READY, .PANEL_DATA);

// file: testbench/tps_panel_model.sv
/*
  Panel model: samples the pins on its capture edge, keeps the words
  shown and counts lines per frame. Assumes the bench arms it only
  while its level inputs are settled.
*/
`timescale 1ns/1ps
// ****************************************
// Panel model
// ****************************************
module tps_panel_model #(
  parameter int PIX_W = 24
) (
  input wire logic pclk,
  input wire logic ls,
  input wire logic fs,
  input wire logic dr,
  input wire logic [PIX_W-1:0] data,
  input wire logic [4:0] ctrl,
  input wire logic armed
);
  logic [PIX_W-1:0] got [$];
  int lines = 0;
  int lines_done = 0;
  int frames = 0;
  logic ls_p = 1'b0;
  logic fs_p = 1'b0;
  logic cap;
  assign cap = pclk ^ ctrl[1];
  // A fresh run starts from inactive syncs
  always @(negedge armed) begin
    ls_p = 1'b0;
    fs_p = 1'b0;
  end
  // Capture at the fall of the normal-polarity clock
  always @(negedge cap) begin
    if (armed) begin
      if (dr ^ ctrl[4]) got.push_back(data);
      if ((fs ^ ctrl[3]) && !fs_p) begin
        lines_done = lines;
        lines = 0;
        frames++;
      end
      if ((ls ^ ctrl[2]) && !ls_p) lines++;
      ls_p = ls ^ ctrl[2];
      fs_p = fs ^ ctrl[3];
    end
  end
endmodule

// file: testbench/tps_timing_tb_top.sv
/*
  Self-checking bench for tps_timing with the panel model.
  Assumes the package, design, model and checker are compiled first.
*/
`timescale 1ns/1ps
// ****************************************
// Bench top
// ****************************************
module tps_timing_tb_top import tps_pkg::*;;
  typedef struct {
    logic [3:0] a;
    logic [15:0] rv;
    logic [15:0] wv;
    logic [15:0] bk;
  } tps_row_t;
  logic REF_CLK = 1'b0;
  logic RST = 1'b1;
  logic [3:0] REG_ADDR = 4'h0;
  logic [15:0] REG_WDATA = 16'h0000;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [15:0] REG_RDATA;
  logic [23:0] PIX_DATA = 24'h000000;
  logic PIX_VALID = 1'b0;
  logic PIX_READY, PANEL_PIXEL_CLOCK, PANEL_LINE_SYNC;
  logic PANEL_FRAME_SYNC, PANEL_DATA_READY;
  logic [23:0] PANEL_DATA;
  logic [4:0] pol = 5'h00;
  logic armed = 1'b0;
  int fails = 0;
  int samples_checked = 0;
  // Address, reset value, write value, read-back; B is read only, C unmapped
  tps_row_t rows [12] = '{
    '{4'h0, 16'h0000, 16'h0000, 16'h0000}, '{4'h1, 16'h0001, 16'h0001, 16'h0001},
    '{4'h2, 16'h000A, 16'h0002, 16'h0002}, '{4'h3, 16'h0014, 16'h0003, 16'h0003},
    '{4'h4, 16'h0140, 16'h0004, 16'h0004}, '{4'h5, 16'h0190, 16'h000A, 16'h000A},
    '{4'h6, 16'h0002, 16'h0001, 16'h0001}, '{4'h7, 16'h0004, 16'h0001, 16'h0001},
    '{4'h8, 16'h00F0, 16'h0002, 16'h0002}, '{4'h9, 16'h00FA, 16'h0004, 16'h0004},
    '{4'hB, 16'h0000, 16'hFFFF, 16'h0000}, '{4'hC, 16'h0000, 16'h1234, 16'h0000}};
  always #4 REF_CLK = ~REF_CLK;
  tps_timing #(.PIX_W(24), .FIFO_DEPTH(8)) dut (.REF_CLK, .RST, .REG_ADDR,
    .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .PIX_DATA, .PIX_VALID,
    .PIX_READY, .PANEL_PIXEL_CLOCK, .PANEL_LINE_SYNC, .PANEL_FRAME_SYNC,
    .PANEL_DATA_READY, .PANEL_DATA);
  tps_panel_model #(.PIX_W(24)) pm (.pclk(PANEL_PIXEL_CLOCK),
    .ls(PANEL_LINE_SYNC), .fs(PANEL_FRAME_SYNC), .dr(PANEL_DATA_READY),
    .data(PANEL_DATA), .ctrl(pol), .armed(armed));
  // Shared compare, register cycles and pixel handshake
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge REF_CLK);
    REG_WR <= 1'b0;
    // Gap cycle, so two writes in a row never drive the strobe twice
    @(posedge REF_CLK);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge REF_CLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
    @(posedge REF_CLK);
  endtask
  task automatic push(input logic [23:0] w);
    PIX_DATA <= w;
    PIX_VALID <= 1'b1;
    // Ready is judged off the edge, where it stands for the taking edge
    #1;
    while (PIX_READY !== 1'b1) begin
      @(posedge REF_CLK);
      #1;
    end
    @(posedge REF_CLK);
  endtask
  task automatic final_report();
    $display("checks=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Main sequence: registers, then a full buffer shown in the first of three frames
  initial begin
    logic [15:0] d;
    repeat (3) @(posedge REF_CLK);
    RST <= 1'b0;
    foreach (rows[i]) begin
      rd(rows[i].a, d);
      check(d, rows[i].rv);
      wr(rows[i].a, rows[i].wv);
      rd(rows[i].a, d);
      check(d, rows[i].bk);
    end
    for (int k = 0; k < 8; k++) push(24'hA50000 + 24'(k));
    PIX_VALID <= 1'b0;
    @(posedge REF_CLK);
    check(PIX_READY, 1'b0);
    armed <= 1'b1;
    wr(TPS_OFF_CTRL, 16'h0001);
    repeat (340) @(posedge REF_CLK);
    check(pm.frames, 3);
    check(pm.lines_done, 4);
    check(pm.got.size(), 8);
    for (int k = 0; k < 8; k++) check(pm.got[k], 24'hA50000 + 24'(k));
    rd(TPS_OFF_STATUS, d);
    check(d[0], 1'b1);
    // Disable with every level inverted, then clear the sticky flag
    armed <= 1'b0;
    wr(TPS_OFF_CTRL, 16'h001E);
    wr(TPS_OFF_STATUS, 16'h0001);
    rd(TPS_OFF_STATUS, d);
    check(d, 16'h0000);
    check({PANEL_PIXEL_CLOCK, PANEL_LINE_SYNC, PANEL_FRAME_SYNC,
      PANEL_DATA_READY}, 4'hF);
    pol <= 5'h1E;
    for (int k = 0; k < 8; k++) push(24'h5A0000 + 24'(k));
    PIX_VALID <= 1'b0;
    pm.got.delete();
    armed <= 1'b1;
    wr(TPS_OFF_CTRL, 16'h001F);
    repeat (200) @(posedge REF_CLK);
    check(pm.got.size(), 8);
    for (int k = 0; k < 8; k++) check(pm.got[k], 24'h5A0000 + 24'(k));
    // Reset in mid-run, while enabled: registers and pins go back
    armed <= 1'b0;
    RST <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    RST <= 1'b0;
    rd(TPS_OFF_CTRL, d);
    check(d, TPS_RST_CTRL);
    rd(TPS_OFF_HSW, d);
    check(d, TPS_RST_HSW);
    check({PANEL_PIXEL_CLOCK, PANEL_LINE_SYNC, PANEL_FRAME_SYNC,
      PANEL_DATA_READY, PIX_READY}, 5'h01);
    check(PANEL_DATA, 24'h000000);
    final_report();
  end
  // Watchdog, several times the expected run length
  initial begin
    #40000;
    fails++;
    final_report();
  end
endmodule
